// [src/uart_chan.sv]
// one uart channel: fifos, serial paths, enables, paged registers, apb slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module uart_chan (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_in,
  input  wire logic        cts_in,
  input  wire logic        rts_in,
  input  wire logic        modem_event,
  input  wire logic        xoff_event,
  output logic             tx_out,
  output logic             irq,
  output logic             sleep_mode
);
  typedef struct packed {
    logic [7:0]  ien;
    logic [7:0]  line_fmt;
    logic [7:0]  fifo_ctrl;
    logic [15:0] divisor;
    logic [7:0]  page_sel;
    logic [7:0]  dir_toggle;
    logic [7:0]  enh_ctrl;
    logic [7:0]  resume1;
    logic [7:0]  resume2;
    logic [7:0]  halt1;
    logic [7:0]  halt2;
    logic [7:0]  add_feat;
    logic [7:0]  retx_cnt;
    logic [7:0]  tx_trig;
    logic [7:0]  rx_trig;
    logic [7:0]  flow_up;
    logic [7:0]  flow_low;
    logic [7:0]  tx_wp;
    logic [7:0]  tx_rp;
    logic [8:0]  tx_cnt;
    logic [7:0]  rx_wp;
    logic [7:0]  rx_rp;
    logic [8:0]  rx_cnt;
    uart_chan_pkg::tx_state_e tx_st;
    logic [15:0] tx_baud;
    logic [3:0]  tx_bit;
    logic [8:0]  tx_sh;
    uart_chan_pkg::rx_state_e rx_st;
    logic [15:0] rx_baud;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic        overrun;
    logic        line_pend;
    logic        txe_pend;
    logic        modem_pend;
    logic        xoff_pend;
    logic        rts_pend;
    logic        cts_pend;
    logic        rts_d;
    logic        cts_d;
    logic        tx_pin;
    logic        irq_o;
    logic [31:0] rdata;
    logic        ready;
  } state_s;
  state_s st_reg;
  state_s st_next;
  logic [7:0] tx_mem [0:255];
  logic [10:0] rx_mem [0:255];
  logic [3:0] wlen;
  logic [3:0] frame_bits;
  logic [8:0] depth;
  logic [7:0] wrap;
  logic       fifo_on;
  logic       paged;
  logic       page4;
  logic       wr_acc;
  logic       rd_acc;
  logic       tx_push;
  logic       tx_pop;
  logic       rx_push;
  logic       rx_pop;
  logic [10:0] rx_entry;
  logic [7:0]  rx_mask;
  logic        par_calc;
  logic        par_err;
  logic        frm_err;
  logic [7:0]  ien_wmask;
  logic [10:0] rx_head;
  always_comb begin
    fifo_on  = st_reg.fifo_ctrl[uart_chan_pkg::FIFO_EN_BIT];
    // extended mode doubles as a plain depth switch; trigger levels not modelled
    depth    = st_reg.add_feat[uart_chan_pkg::EXT_DEPTH_BIT] ? 9'(uart_chan_pkg::DEPTH_EXT)
                                                           : 9'(uart_chan_pkg::DEPTH_STD);
    if (!fifo_on) depth = 9'd1;
    wrap     = 8'(depth - 9'd1);
    wlen     = 4'd5 + {2'b00, st_reg.line_fmt[1:0]};
    frame_bits = wlen + {3'b000, st_reg.line_fmt[3]};
    rx_mask  = 8'hFF >> (4'd8 - wlen);
    paged    = st_reg.line_fmt == uart_chan_pkg::PAGED_KEY;
    page4    = paged && st_reg.page_sel[0];
    wr_acc   = psel && penable && pwrite && !st_reg.ready;
    rd_acc   = psel && penable && !pwrite && !st_reg.ready;
    rx_head  = rx_mem[st_reg.rx_rp];
    ien_wmask = st_reg.enh_ctrl[uart_chan_pkg::ENH_BIT] ? 8'hFF : 8'h0F;
    tx_push  = wr_acc && paddr == uart_chan_pkg::ADDR_DATA && st_reg.tx_cnt < depth;
    rx_pop   = rd_acc && paddr == uart_chan_pkg::ADDR_DATA && st_reg.rx_cnt != 9'd0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    par_calc = ^(st_reg.rx_sh[7:0] & rx_mask) ^ ~st_reg.line_fmt[4];
    par_err  = st_reg.line_fmt[3] && (par_calc != st_reg.rx_sh[8]);
    frm_err  = !rx_in;
    rx_entry = {frm_err, par_err, 1'b0, st_reg.rx_sh[7:0] & rx_mask};
    st_next  = st_reg;
    st_next.ready = psel && penable && !st_reg.ready;
    // transmitter
    case (st_reg.tx_st)
      uart_chan_pkg::TX_IDLE: begin
        st_next.tx_pin = 1'b1;
        if (st_reg.tx_cnt != 9'd0) begin
          tx_pop = 1'b1;
          st_next.tx_sh = {^tx_mem[st_reg.tx_rp] ^ ~st_reg.line_fmt[4], tx_mem[st_reg.tx_rp]};
          st_next.tx_st = uart_chan_pkg::TX_START;
          st_next.tx_baud = st_reg.divisor;
          st_next.tx_pin = 1'b0;
        end
      end
      uart_chan_pkg::TX_START, uart_chan_pkg::TX_DATA: begin
        st_next.tx_baud = st_reg.tx_baud - 16'd1;
        if (st_reg.tx_baud <= 16'd1) begin
          st_next.tx_baud = st_reg.divisor;
          st_next.tx_st = uart_chan_pkg::TX_DATA;
          st_next.tx_bit = st_reg.tx_bit + 4'd1;
          if (st_reg.tx_bit == frame_bits) begin
            st_next.tx_st = uart_chan_pkg::TX_STOP;
            st_next.tx_pin = 1'b1;
          end else if (st_reg.tx_bit == wlen) begin
            st_next.tx_pin = st_reg.tx_sh[8];
          end else begin
            st_next.tx_pin = st_reg.tx_sh[st_reg.tx_bit[2:0]];
          end
        end
      end
      uart_chan_pkg::TX_STOP: begin
        st_next.tx_baud = st_reg.tx_baud - 16'd1;
        if (st_reg.tx_baud <= 16'd1) begin
          st_next.tx_bit = st_reg.tx_bit + 4'd1;
          st_next.tx_baud = st_reg.divisor;
          if (st_reg.tx_bit >= frame_bits + 4'd1 + {3'b000, st_reg.line_fmt[2]}) begin
            st_next.tx_st = uart_chan_pkg::TX_IDLE;
            st_next.tx_bit = 4'd0;
          end
        end
      end
      default: st_next.tx_st = uart_chan_pkg::TX_IDLE;
    endcase
    // status read clears first, so a same-cycle error still lands
    if (rd_acc && paddr == uart_chan_pkg::ADDR_LINE_STAT) begin
      st_next.line_pend = 1'b0;
      st_next.overrun = 1'b0;
    end
    // receiver: sample at mid bit
    case (st_reg.rx_st)
      uart_chan_pkg::RX_IDLE: begin
        if (!rx_in) begin
          st_next.rx_st = uart_chan_pkg::RX_START;
          st_next.rx_baud = {1'b0, st_reg.divisor[15:1]};
          st_next.rx_bit = 4'd0;
        end
      end
      uart_chan_pkg::RX_START: begin
        st_next.rx_baud = st_reg.rx_baud - 16'd1;
        if (st_reg.rx_baud <= 16'd1) begin
          st_next.rx_baud = st_reg.divisor;
          // false start bits are rejected here
          st_next.rx_st = rx_in ? uart_chan_pkg::RX_IDLE : uart_chan_pkg::RX_DATA;
        end
      end
      uart_chan_pkg::RX_DATA: begin
        st_next.rx_baud = st_reg.rx_baud - 16'd1;
        if (st_reg.rx_baud <= 16'd1) begin
          st_next.rx_baud = st_reg.divisor;
          st_next.rx_bit = st_reg.rx_bit + 4'd1;
          if (st_reg.rx_bit < wlen) st_next.rx_sh[st_reg.rx_bit[2:0]] = rx_in;
          else st_next.rx_sh[8] = rx_in;
          if (st_reg.rx_bit + 4'd1 == frame_bits) st_next.rx_st = uart_chan_pkg::RX_STOP;
        end
      end
      uart_chan_pkg::RX_STOP: begin
        st_next.rx_baud = st_reg.rx_baud - 16'd1;
        if (st_reg.rx_baud <= 16'd1) begin
          st_next.rx_st = uart_chan_pkg::RX_IDLE;
          st_next.rx_sh = 9'h000;
          if (st_reg.rx_cnt < depth) rx_push = 1'b1;
          else st_next.overrun = 1'b1;
          st_next.line_pend = st_next.line_pend | frm_err | par_err | !(st_reg.rx_cnt < depth);
        end
      end
      default: st_next.rx_st = uart_chan_pkg::RX_IDLE;
    endcase
    // fifo pointers, wrap at current depth
    if (tx_push) st_next.tx_wp = (st_reg.tx_wp >= wrap) ? 8'h00 : st_reg.tx_wp + 8'h01;
    if (tx_pop) st_next.tx_rp = (st_reg.tx_rp >= wrap) ? 8'h00 : st_reg.tx_rp + 8'h01;
    st_next.tx_cnt = st_reg.tx_cnt + {8'h00, tx_push} - {8'h00, tx_pop};
    if (rx_push) st_next.rx_wp = (st_reg.rx_wp >= wrap) ? 8'h00 : st_reg.rx_wp + 8'h01;
    if (rx_pop) st_next.rx_rp = (st_reg.rx_rp >= wrap) ? 8'h00 : st_reg.rx_rp + 8'h01;
    st_next.rx_cnt = st_reg.rx_cnt + {8'h00, rx_push} - {8'h00, rx_pop};
    // pointers left over from fifo mode must not move the single slot
    if (!fifo_on) begin
      st_next.tx_wp = 8'h00;
      st_next.tx_rp = 8'h00;
      st_next.rx_wp = 8'h00;
      st_next.rx_rp = 8'h00;
    end
    // edge sources; set wins over clear
    st_next.rts_d = rts_in;
    st_next.cts_d = cts_in;
    if (rd_acc && paddr == uart_chan_pkg::ADDR_FIFO_CTRL) begin
      st_next.xoff_pend = 1'b0;
      st_next.rts_pend  = 1'b0;
      st_next.cts_pend  = 1'b0;
      st_next.txe_pend  = 1'b0;
    end
    if (rd_acc && paddr == uart_chan_pkg::ADDR_MODEM_ST) st_next.modem_pend = 1'b0;
    if (tx_push) st_next.txe_pend = 1'b0;
    if (tx_pop && st_reg.tx_cnt == 9'd1) st_next.txe_pend = 1'b1;
    if (modem_event) st_next.modem_pend = 1'b1;
    if (xoff_event) st_next.xoff_pend = 1'b1;
    if (rts_in && !st_reg.rts_d) st_next.rts_pend = 1'b1;
    if (cts_in && !st_reg.cts_d) st_next.cts_pend = 1'b1;
    // register writes
    if (wr_acc) begin
      if (paddr == uart_chan_pkg::ADDR_IEN)
        st_next.ien = (pwdata[7:0] & ien_wmask) | (st_reg.ien & ~ien_wmask);
      if (paddr == uart_chan_pkg::ADDR_FIFO_CTRL) begin
        st_next.fifo_ctrl = pwdata[7:0] & 8'hF9;
        if (pwdata[1]) begin
          st_next.rx_wp = 8'h00;
          st_next.rx_rp = 8'h00;
          st_next.rx_cnt = 9'd0;
        end
        if (pwdata[2]) begin
          st_next.tx_wp = 8'h00;
          st_next.tx_rp = 8'h00;
          st_next.tx_cnt = 9'd0;
        end
      end
      if (paddr == uart_chan_pkg::ADDR_LINE_FMT) st_next.line_fmt = pwdata[7:0];
      if (paddr == uart_chan_pkg::ADDR_DIVISOR) st_next.divisor = pwdata[15:0];
      if (paddr[11:5] == uart_chan_pkg::ADDR_PAGED[11:5] && paged) begin
        if (!page4) begin
          case (paddr[4:2])
            uart_chan_pkg::IDX_PAGE_SEL: st_next.page_sel = {7'h00, pwdata[0]};
            uart_chan_pkg::IDX_DIR_TOGGLE: st_next.dir_toggle = pwdata[7:0] & 8'hF3;
            uart_chan_pkg::IDX_ENH_CTRL: st_next.enh_ctrl = pwdata[7:0];
            uart_chan_pkg::IDX_RESUME1: st_next.resume1 = pwdata[7:0];
            uart_chan_pkg::IDX_RESUME2: st_next.resume2 = pwdata[7:0];
            uart_chan_pkg::IDX_HALT1: st_next.halt1 = pwdata[7:0];
            uart_chan_pkg::IDX_HALT2: st_next.halt2 = pwdata[7:0];
            default: st_next.page_sel = st_reg.page_sel;
          endcase
        end else begin
          case (paddr[4:2])
            uart_chan_pkg::IDX_PAGE_SEL: st_next.page_sel = {7'h00, pwdata[0]};
            uart_chan_pkg::IDX_ADD_FEAT: st_next.add_feat = pwdata[7:0] & 8'h31;
            uart_chan_pkg::IDX_RETX_CNT: st_next.retx_cnt = pwdata[7:0] & 8'h03;
            uart_chan_pkg::IDX_TX_TRIG: st_next.tx_trig = pwdata[7:0];
            uart_chan_pkg::IDX_RX_TRIG: st_next.rx_trig = pwdata[7:0];
            uart_chan_pkg::IDX_FLOW_UP: st_next.flow_up = pwdata[7:0];
            uart_chan_pkg::IDX_FLOW_LOW: st_next.flow_low = pwdata[7:0];
            default: st_next.page_sel = st_reg.page_sel;
          endcase
        end
      end
    end
    // read mux
    st_next.rdata = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        uart_chan_pkg::ADDR_DATA:
          st_next.rdata = {21'h00_0000, (st_reg.rx_cnt != 9'd0) ? rx_head : 11'h000};
        uart_chan_pkg::ADDR_IEN: st_next.rdata = {24'h00_0000, st_reg.ien};
        uart_chan_pkg::ADDR_FIFO_CTRL: st_next.rdata = {24'h00_0000, st_reg.fifo_ctrl};
        uart_chan_pkg::ADDR_LINE_FMT: st_next.rdata = {24'h00_0000, st_reg.line_fmt};
        uart_chan_pkg::ADDR_LINE_STAT:
          st_next.rdata = {24'h00_0000, 1'b0, st_reg.tx_cnt == 9'd0 && st_reg.tx_st == uart_chan_pkg::TX_IDLE,
                           st_reg.tx_cnt == 9'd0, 3'b000, st_reg.overrun, st_reg.rx_cnt != 9'd0};
        uart_chan_pkg::ADDR_MODEM_ST:
          st_next.rdata = {24'h00_0000, st_reg.cts_pend, st_reg.rts_pend, st_reg.xoff_pend,
                           st_reg.modem_pend, st_reg.line_pend, st_reg.txe_pend, 2'b00};
        uart_chan_pkg::ADDR_DIVISOR: st_next.rdata = {16'h0000, st_reg.divisor};
        default: begin
          if (paddr[11:5] == uart_chan_pkg::ADDR_PAGED[11:5] && paged) begin
            case ({page4, paddr[4:2]})
              {1'b0, uart_chan_pkg::IDX_PAGE_SEL}, {1'b1, uart_chan_pkg::IDX_PAGE_SEL}:
                st_next.rdata = {24'h00_0000, uart_chan_pkg::PAGE_SEL_FIXED | st_reg.page_sel};
              {1'b0, uart_chan_pkg::IDX_DIR_TOGGLE}: st_next.rdata = {24'h00_0000, st_reg.dir_toggle};
              {1'b0, uart_chan_pkg::IDX_ENH_CTRL}: st_next.rdata = {24'h00_0000, st_reg.enh_ctrl};
              {1'b0, uart_chan_pkg::IDX_RESUME1}: st_next.rdata = {24'h00_0000, st_reg.resume1};
              {1'b0, uart_chan_pkg::IDX_RESUME2}: st_next.rdata = {24'h00_0000, st_reg.resume2};
              {1'b0, uart_chan_pkg::IDX_HALT1}: st_next.rdata = {24'h00_0000, st_reg.halt1};
              {1'b0, uart_chan_pkg::IDX_HALT2}: st_next.rdata = {24'h00_0000, st_reg.halt2};
              {1'b1, uart_chan_pkg::IDX_ADD_FEAT}: st_next.rdata = {24'h00_0000, st_reg.add_feat};
              {1'b1, uart_chan_pkg::IDX_RETX_CNT}: st_next.rdata = {24'h00_0000, st_reg.retx_cnt};
              {1'b1, uart_chan_pkg::IDX_TX_TRIG}: st_next.rdata = {24'h00_0000, st_reg.tx_trig};
              {1'b1, uart_chan_pkg::IDX_RX_TRIG}: st_next.rdata = {24'h00_0000, st_reg.rx_trig};
              {1'b1, uart_chan_pkg::IDX_FLOW_UP}: st_next.rdata = {24'h00_0000, st_reg.flow_up};
              {1'b1, uart_chan_pkg::IDX_FLOW_LOW}: st_next.rdata = {24'h00_0000, st_reg.flow_low};
              default: st_next.rdata = 32'h0000_0000;
            endcase
          end
        end
      endcase
    end
    st_next.tx_pin = (st_reg.tx_st == uart_chan_pkg::TX_IDLE && !tx_pop) ? 1'b1 : st_next.tx_pin;
    // interrupt output, one cycle behind its sources
    st_next.irq_o = |(st_reg.ien[3:0] & {st_reg.modem_pend, st_reg.line_pend, st_reg.txe_pend,
                                         st_reg.rx_cnt != 9'd0}) |
                    |(st_reg.ien[7:5] & {st_reg.cts_pend, st_reg.rts_pend, st_reg.xoff_pend});
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.divisor <= uart_chan_pkg::DIVISOR_RESET;
      st_reg.tx_st <= uart_chan_pkg::TX_IDLE;
      st_reg.rx_st <= uart_chan_pkg::RX_IDLE;
      st_reg.tx_pin <= 1'b1;
      // pins idle high, so no false rising edge right after reset
      st_reg.rts_d <= 1'b1;
      st_reg.cts_d <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // storage has no reset; pointers, counts and the rest of st_reg do
  always_ff @(posedge ref_clk) begin
    if (tx_push) tx_mem[st_reg.tx_wp] <= pwdata[7:0];
    if (rx_push) rx_mem[st_reg.rx_wp] <= rx_entry;
  end
  assign prdata     = st_reg.rdata;
  assign pready     = st_reg.ready;
  assign pslverr    = 1'b0;
  assign tx_out     = st_reg.tx_pin;
  assign irq        = st_reg.irq_o;
  assign sleep_mode = st_reg.ien[4];
endmodule : uart_chan
`default_nettype wire

// [src/uart_chan_pkg.sv]
// constants, register map and state types for one uart channel
// Operation
// - tx fifo holds 64, or 256 extended
// - fifo head loads shifter, serialised out
// - fifo off: pending tx byte in entry zero
// - writes to full tx fifo dropped
// - rx fifo holds 64, or 256 extended
// - rx shifter assembles character into fifo
// - rx format follows line format control
// - fifo off: rx character in entry zero
// - rx characters dropped when fifo full
// - each rx entry keeps its error bits
// - enables gate seven interrupt types
// - rts/cts sources fire on rising edge
// - all enables clear means no interrupt
// - bit 7 cts enable, needs enhanced bit
// - bit 6 rts enable, needs enhanced bit
// - bit 5 xoff enable, needs enhanced bit
// - bit 4 sleep enable, needs enhanced bit
// - bit 3 modem status enable
// - bit 2 line status enable
// - bit 1 tx holding empty enable
// - bit 0 rx data available enable
package uart_chan_pkg;
  localparam logic [11:0] ADDR_DATA      = 12'h000;
  localparam logic [11:0] ADDR_IEN       = 12'h004;
  localparam logic [11:0] ADDR_FIFO_CTRL = 12'h008;
  localparam logic [11:0] ADDR_LINE_FMT  = 12'h00C;
  localparam logic [11:0] ADDR_LINE_STAT = 12'h014;
  localparam logic [11:0] ADDR_MODEM_ST  = 12'h018;
  localparam logic [11:0] ADDR_DIVISOR   = 12'h01C;
  localparam logic [11:0] ADDR_PAGED     = 12'h100;
  localparam logic [2:0] IDX_PAGE_SEL   = 3'h0;
  localparam logic [2:0] IDX_DIR_TOGGLE = 3'h1;
  localparam logic [2:0] IDX_ENH_CTRL   = 3'h2;
  localparam logic [2:0] IDX_RESUME1    = 3'h4;
  localparam logic [2:0] IDX_RESUME2    = 3'h5;
  localparam logic [2:0] IDX_HALT1      = 3'h6;
  localparam logic [2:0] IDX_HALT2      = 3'h7;
  localparam logic [2:0] IDX_ADD_FEAT   = 3'h1;
  localparam logic [2:0] IDX_RETX_CNT   = 3'h2;
  localparam logic [2:0] IDX_TX_TRIG    = 3'h4;
  localparam logic [2:0] IDX_RX_TRIG    = 3'h5;
  localparam logic [2:0] IDX_FLOW_UP    = 3'h6;
  localparam logic [2:0] IDX_FLOW_LOW   = 3'h7;
  localparam logic [7:0] PAGED_KEY      = 8'hBF;
  localparam logic [7:0] PAGE_SEL_FIXED = 8'hA4;
  localparam int ENH_BIT       = 4;
  localparam int EXT_DEPTH_BIT = 0;
  localparam int FIFO_EN_BIT   = 0;
  localparam int DEPTH_STD     = 64;
  localparam int DEPTH_EXT     = 256;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;
endpackage : uart_chan_pkg

// [dv/uart_chan_checker.sv]
// concurrent checks on the uart channel ports
`timescale 1ns/1ps
`default_nettype none
module uart_chan_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_out,
  input wire logic        irq,
  input wire logic        sleep_mode
);
  logic done;
  logic ien_seen_reg;
  logic tx_seen_reg;
  // any attempt counts, so the enhanced check stays conservative
  logic enh_seen_reg;
  assign done = psel && penable && pready;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_seen_reg <= 1'b0;
      tx_seen_reg  <= 1'b0;
      enh_seen_reg <= 1'b0;
    end else if (done && pwrite) begin
      ien_seen_reg <= ien_seen_reg || paddr == uart_chan_pkg::ADDR_IEN;
      tx_seen_reg  <= tx_seen_reg || paddr == uart_chan_pkg::ADDR_DATA;
      enh_seen_reg <= enh_seen_reg || (paddr == 12'h108 && pwdata[4]);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_pready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_no_error: assert property (!pslverr)
    else $error("pslverr raised");
  a_unmapped_zero: assert property (done && !pwrite && paddr inside {[12'h020:12'h0FC]}
    |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_ien_upper: assert property (done && !pwrite && paddr == uart_chan_pkg::ADDR_IEN
    && !enh_seen_reg |-> prdata[7:4] == 4'h0) else $error("upper enables set without enhanced");
  a_irq_quiet: assert property (!ien_seen_reg |-> !irq)
    else $error("irq with enables cleared");
  a_tx_quiet: assert property (!tx_seen_reg |-> tx_out)
    else $error("tx line left idle without data");
  a_sleep_cause: assert property ($rose(sleep_mode) |-> enh_seen_reg && ien_seen_reg)
    else $error("sleep mode without enable write");
  c_tx_write: cover property (done && pwrite && paddr == uart_chan_pkg::ADDR_DATA);
  c_irq_rise: cover property ($rose(irq));
  c_sleep_rise: cover property ($rose(sleep_mode));
endmodule : uart_chan_checker
bind uart_chan uart_chan_checker uart_chan_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .irq(irq),
  .sleep_mode(sleep_mode));
`default_nettype wire

// [dv/uart_far_end.sv]
// remote serial device: sends characters on rx_in, collects bytes from tx_out
`timescale 1ns/1ps
`default_nettype none
module uart_far_end #(
  parameter int DIV = 64
) (
  input  wire logic ref_clk,
  input  wire logic tx_out,
  output var  logic rx_in
);
  logic [7:0] got[$];
  logic [7:0] byte_in;
  task bit_out(input logic b);
    rx_in <= b;
    repeat (DIV) @(posedge ref_clk);
  endtask : bit_out
  // even parity; bad_par and bad_stop break the frame on purpose
  task send(input logic [7:0] d, input logic par, input logic bad_par, input logic bad_stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (par) bit_out(^d ^ bad_par);
    bit_out(!bad_stop);
    bit_out(1'b1);
  endtask : send
  initial begin
    rx_in = 1'b1;
    forever begin
      @(negedge tx_out);
      repeat (DIV / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge ref_clk);
        byte_in[i] = tx_out;
      end
      got.push_back(byte_in);
      repeat (DIV) @(posedge ref_clk);
    end
  end
endmodule : uart_far_end
`default_nettype wire

// [dv/test_uart_buffers_and_interrupt_enables.sv]
// directed bench for the uart channel: apb access, serial traffic, enables
`timescale 1ns/1ps
`default_nettype none
module test_uart_buffers_and_interrupt_enables;
  localparam int DIV = 32;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready, pslverr, rx_in, tx_out, irq, sleep_mode;
  logic        cts_in = 1'b1;
  logic        rts_in = 1'b1;
  logic        modem_event = 1'b0;
  logic        xoff_event = 1'b0;
  logic [7:0]  src_en [4] = '{8'hC0, 8'h80, 8'h20, 8'h08};
  int          errors = 0;
  int          comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  uart_chan uart_chan_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .cts_in(cts_in), .rts_in(rts_in),
    .modem_event(modem_event), .xoff_event(xoff_event), .tx_out(tx_out), .irq(irq),
    .sleep_mode(sleep_mode));
  uart_far_end #(.DIV(DIV)) uart_far_end_i (.ref_clk(ref_clk), .tx_out(tx_out), .rx_in(rx_in));
  task final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // read data taken while pready stands, released at the sampling edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    if (n >= 50) errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check($sformatf("read %h", a), rdat, exp);
  endtask : rdc
  task wait_got(input int k);
    int n;
    n = 0;
    while (uart_far_end_i.got.size() < k && n < 60000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (20 * DIV) @(posedge ref_clk);
    check("tx count", 32'(uart_far_end_i.got.size()), 32'(k));
  endtask : wait_got
  task raise_source(input int i);
    @(posedge ref_clk);
    case (i)
      0: rts_in <= 1'b1;
      1: cts_in <= 1'b1;
      2: xoff_event <= 1'b1;
      default: modem_event <= 1'b1;
    endcase
    @(posedge ref_clk);
    xoff_event  <= 1'b0;
    modem_event <= 1'b0;
  endtask : raise_source
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    check("sleep", 32'(sleep_mode), 32'h0000_0000);
    rdc(uart_chan_pkg::ADDR_IEN, 32'h0000_0000);
    rdc(12'h0F0, 32'h0000_0000);
    wr(uart_chan_pkg::ADDR_DIVISOR, 32'(DIV));
    wr(uart_chan_pkg::ADDR_LINE_FMT, 32'h0000_0003);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_00FF);
    rdc(uart_chan_pkg::ADDR_IEN, 32'h0000_000F);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0000);
    wr(12'h114, 32'h0000_005A);
    wr(uart_chan_pkg::ADDR_LINE_FMT, 32'h0000_00BF);
    wr(12'h100, 32'h0000_0001);
    rdc(12'h114, 32'h0000_0000);
    wr(12'h114, 32'h0000_005A);
    rdc(12'h114, 32'h0000_005A);
    wr(12'h100, 32'h0000_0000);
    wr(12'h108, 32'h0000_0010);
    wr(uart_chan_pkg::ADDR_LINE_FMT, 32'h0000_0003);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0010);
    repeat (3) @(posedge ref_clk);
    check("sleep", 32'(sleep_mode), 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(uart_chan_pkg::ADDR_IEN, {24'h00_0000, src_en[i]});
      @(posedge ref_clk);
      if (i == 0) begin
        rts_in <= 1'b0;
        cts_in <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      check("irq", 32'(irq), 32'h0000_0000);
      raise_source(i);
      repeat (4) @(posedge ref_clk);
      check("irq", 32'(irq), 32'h0000_0001);
      wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      check("irq", 32'(irq), 32'h0000_0000);
      apb(1'b0, uart_chan_pkg::ADDR_FIFO_CTRL, 32'h0000_0000);
      apb(1'b0, uart_chan_pkg::ADDR_MODEM_ST, 32'h0000_0000);
    end
    wr(uart_chan_pkg::ADDR_FIFO_CTRL, 32'h0000_0001);
    for (int k = 0; k < 70; k++) wr(uart_chan_pkg::ADDR_DATA, 32'(k));
    wait_got(65);
    check("tx last", 32'(uart_far_end_i.got[64]), 32'h0000_0040);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    check("irq", 32'(irq), 32'h0000_0001);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0000);
    wr(uart_chan_pkg::ADDR_LINE_FMT, 32'h0000_00BF);
    wr(12'h100, 32'h0000_0001);
    wr(12'h104, 32'h0000_0001);
    wr(uart_chan_pkg::ADDR_LINE_FMT, 32'h0000_0003);
    uart_far_end_i.got.delete();
    for (int k = 0; k < 70; k++) wr(uart_chan_pkg::ADDR_DATA, 32'(k));
    wait_got(70);
    check("tx ext", 32'(uart_far_end_i.got[69]), 32'h0000_0045);
    wr(uart_chan_pkg::ADDR_FIFO_CTRL, 32'h0000_0000);
    uart_far_end_i.got.delete();
    wr(uart_chan_pkg::ADDR_DATA, 32'h0000_00A1);
    wr(uart_chan_pkg::ADDR_DATA, 32'h0000_00B2);
    wr(uart_chan_pkg::ADDR_DATA, 32'h0000_00C3);
    wait_got(2);
    check("tx byte", 32'(uart_far_end_i.got[1]), 32'h0000_00B2);
    uart_far_end_i.send(8'h3C, 1'b0, 1'b0, 1'b0);
    uart_far_end_i.send(8'h77, 1'b0, 1'b0, 1'b0);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    check("irq", 32'(irq), 32'h0000_0001);
    rdc(uart_chan_pkg::ADDR_DATA, 32'h0000_003C);
    apb(1'b0, uart_chan_pkg::ADDR_LINE_STAT, 32'h0000_0000);
    check("rx ready", 32'(rdat[0]), 32'h0000_0000);
    check("irq", 32'(irq), 32'h0000_0000);
    wr(uart_chan_pkg::ADDR_IEN, 32'h0000_0000);
    wr(uart_chan_pkg::ADDR_FIFO_CTRL, 32'h0000_0007);
    wr(uart_chan_pkg::ADDR_LINE_FMT, 32'h0000_001B);
    uart_far_end_i.send(8'h55, 1'b1, 1'b0, 1'b0);
    uart_far_end_i.send(8'h81, 1'b1, 1'b1, 1'b0);
    uart_far_end_i.send(8'h42, 1'b1, 1'b0, 1'b1);
    rdc(uart_chan_pkg::ADDR_DATA, 32'h0000_0055);
    rdc(uart_chan_pkg::ADDR_DATA, 32'h0000_0281);
    rdc(uart_chan_pkg::ADDR_DATA, 32'h0000_0442);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule : test_uart_buffers_and_interrupt_enables
`default_nettype wire
